// ==== verilog/link_train_partner.sv ====
// Link training partner: frames out, frames in, AXI4-Lite registers.
// Assumes rxBit is the partner's line, one bit per clk_sys, in sync.
//
// Operation
// - Frames sent back to back without gaps
// - Frame is marker, control channel, training
// - Every frame starts with marker FFFF0000
// - Control carries update then status, DME coded
// - Control cells run at one eighth line rate
// - Training is two PRBS11 runs, two zeros
// - Reserved bits sent zero, ignored on receive
// - Update bit 13 requests preset coefficients
// - Update bit 12 requests coefficient initialisation
// - Two-bit tap requests: increment, decrement, hold
// - Status bit 15 reports receiver ready
// - Two-bit tap status: max, min, updated
//
// Chosen here: register access over AXI4-Lite and the register addresses.
module link_train_partner (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Serial line
  output logic txBit,
  input wire logic rxBit,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import link_train_pkg::*;

  // Sanitised update field: reserved bits and reserved codes cleared
  function automatic logic [15:0] cleanUpd(input logic [15:0] v);
    logic [15:0] r;
    r = v & ~UPD_RES_MASK;
    for (int t = 0; t < 3; t++) begin
      if (r[t*2 +: 2] == TAP_RES) begin
        r[t*2 +: 2] = TAP_HOLD;
      end
    end
    // Preset or initialise carries no tap step with it
    if (r[PRESET_BIT] || r[INIT_BIT]) begin
      r[5:0] = {TAP_HOLD, TAP_HOLD, TAP_HOLD};
    end
    cleanUpd = r;
  endfunction : cleanUpd

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] awAddr_q, awAddr_d, wData_q, wData_d, rdata_q, rdata_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic enable_q, enable_d;
  logic [15:0] txUpd_q, txUpd_d, txStat_q, txStat_d;
  logic [15:0] rxUpd_q, rxStat_q;
  logic locked_q;
  logic [12:0] errLast_q;
  logic [31:0] wMerged;

  assign awready = !awHeld_q;
  assign wready = !wHeld_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // Write and read channel next state
  always_comb begin
    awHeld_d = awHeld_q;
    awAddr_d = awAddr_q;
    wHeld_d = wHeld_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    enable_d = enable_q;
    txUpd_d = txUpd_q;
    txStat_d = txStat_q;
    wMerged = 32'h00000000;
    if (awvalid && awready) begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wready) begin
      wHeld_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    // Both halves held: commit once the response slot is free
    if (awHeld_q && wHeld_q && !bvalid_q) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      unique case (awAddr_q)
        OFF_CTRL: begin
          wMerged = applyStrobe({31'h00000000, enable_q}, wData_q, wStrb_q);
          enable_d = wMerged[0];
        end
        OFF_TX_UPD: begin
          wMerged = applyStrobe({16'h0000, txUpd_q}, wData_q, wStrb_q);
          txUpd_d = cleanUpd(wMerged[15:0]);
        end
        OFF_TX_STAT: begin
          wMerged = applyStrobe({16'h0000, txStat_q}, wData_q, wStrb_q);
          txStat_d = wMerged[15:0] & ~STAT_RES_MASK;
        end
        OFF_RX_UPD, OFF_RX_STAT, OFF_LINK, OFF_ERRS: begin
          bresp_d = RESP_OKAY; // Read-only, write dropped
        end
        default: begin
          bresp_d = RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case (araddr)
        OFF_CTRL: rdata_d = {31'h00000000, enable_q};
        OFF_TX_UPD: rdata_d = {16'h0000, txUpd_q};
        OFF_TX_STAT: rdata_d = {16'h0000, txStat_q};
        OFF_RX_UPD: rdata_d = {16'h0000, rxUpd_q};
        OFF_RX_STAT: rdata_d = {16'h0000, rxStat_q};
        OFF_LINK: rdata_d = {29'h00000000, enable_q, rxStat_q[RXREADY_BIT], locked_q};
        OFF_ERRS: rdata_d = {19'h00000, errLast_q};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  // Bus and control registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 32'h00000000;
      wHeld_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
      enable_q <= 1'b0;
      txUpd_q <= 16'h0000;
      txStat_q <= 16'h0000;
    end else begin
      awHeld_q <= awHeld_d;
      awAddr_q <= awAddr_d;
      wHeld_q <= wHeld_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      enable_q <= enable_d;
      txUpd_q <= txUpd_d;
      txStat_q <= txStat_d;
    end
  end

  // ----------------------------------------------------------------
  // Frame transmitter
  // ----------------------------------------------------------------
  logic [12:0] posTx_q, posTx_d, offTx;
  logic txBit_q, txBit_d, prbsBit, inCtrlTx, inTrainTx;
  logic [31:0] txWord;

  assign offTx = posTx_q - CTRL_START;
  assign inCtrlTx = enable_q && posTx_q >= CTRL_START && posTx_q < TRAIN_START;
  assign inTrainTx = enable_q && posTx_q >= TRAIN_START && posTx_q <= TRAIN_LAST;
  assign txWord = {txStat_q, txUpd_q};
  assign txBit = txBit_q;

  prbs11_gen u_prbs (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(!inTrainTx),
    .advance(inTrainTx),
    .bitOut(prbsBit)
  );

  // Bit position and line level of the next bit
  always_comb begin
    posTx_d = posTx_q + 13'h0001;
    txBit_d = 1'b0;
    if (!enable_q || posTx_q == FRAME_LEN - 13'h0001) begin
      posTx_d = 13'h0000;
    end
    if (!enable_q) begin
      txBit_d = 1'b0;
    end else if (posTx_q < CTRL_START) begin
      txBit_d = MARKER[5'h1F - posTx_q[4:0]];
    end else if (inCtrlTx) begin
      // One cell of eight bits per control bit
      if (offTx[2:0] == CELL_EDGE) begin
        txBit_d = ~txBit_q;
      end else if (offTx[2:0] == CELL_MID && txWord[offTx[7:3]]) begin
        txBit_d = ~txBit_q;
      end else begin
        txBit_d = txBit_q;
      end
    end else if (inTrainTx) begin
      txBit_d = prbsBit;
    end else begin
      txBit_d = 1'b0;
    end
  end

  // Transmitter registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      posTx_q <= 13'h0000;
      txBit_q <= 1'b0;
    end else begin
      posTx_q <= posTx_d;
      txBit_q <= txBit_d;
    end
  end

  // ----------------------------------------------------------------
  // Frame receiver
  // ----------------------------------------------------------------
  logic [31:0] rxSh_q, rxSh_d, rxWord_q, rxWord_d;
  logic [12:0] posRx_q, posRx_d, curPos, offRx, errAcc_q, errAcc_d, errLast_d;
  logic [10:0] hist_q, hist_d;
  logic [15:0] rxUpd_d, rxStat_d;
  logic locked_d, sampA_q, sampA_d, markerHit, inCtrlRx, dBit;

  assign markerHit = rxSh_q == MARKER;
  assign curPos = locked_q ? posRx_q : CTRL_START;
  assign offRx = curPos - CTRL_START;
  assign inCtrlRx = curPos >= CTRL_START && curPos < TRAIN_START;
  assign dBit = rxBit != sampA_q;

  // Alignment, control decode and error count
  always_comb begin
    rxSh_d = {rxSh_q[30:0], rxBit};
    locked_d = locked_q;
    posRx_d = posRx_q;
    rxWord_d = rxWord_q;
    sampA_d = sampA_q;
    rxUpd_d = rxUpd_q;
    rxStat_d = rxStat_q;
    hist_d = hist_q;
    errAcc_d = errAcc_q;
    errLast_d = errLast_q;
    if (!locked_q && markerHit) begin
      locked_d = 1'b1;
    end
    if (locked_q && curPos == CTRL_START && !markerHit) begin
      locked_d = 1'b0;
    end
    if (locked_d) begin
      posRx_d = (curPos == FRAME_LEN - 13'h0001) ? 13'h0000 : curPos + 13'h0001;
    end else begin
      posRx_d = 13'h0000;
      errAcc_d = 13'h0000;
    end
    // Control decode only once aligned
    if (locked_d && inCtrlRx) begin
      if (offRx[2:0] == SAMPLE_A) begin
        sampA_d = rxBit;
      end
      if (offRx[2:0] == SAMPLE_B) begin
        rxWord_d = {dBit, rxWord_q[31:1]};
        if (offRx[7:3] == LAST_CELL) begin
          rxUpd_d = rxWord_d[15:0] & ~UPD_RES_MASK;
          rxStat_d = rxWord_d[31:16] & ~STAT_RES_MASK;
        end
      end
    end
    // Self-synchronised PRBS11 check over the training field
    if (locked_d && curPos >= TRAIN_START && curPos <= TRAIN_LAST) begin
      hist_d = {hist_q[9:0], rxBit};
      if (curPos >= CHECK_START && rxBit != prbsFb(hist_q)) begin
        errAcc_d = errAcc_q + 13'h0001;
      end
    end
    if (locked_d && curPos == FRAME_LEN - 13'h0001) begin
      errLast_d = errAcc_d;
      errAcc_d = 13'h0000;
    end
  end

  // Receiver registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxSh_q <= 32'h00000000;
      locked_q <= 1'b0;
      posRx_q <= 13'h0000;
      rxWord_q <= 32'h00000000;
      sampA_q <= 1'b0;
      rxUpd_q <= 16'h0000;
      rxStat_q <= 16'h0000;
      hist_q <= 11'h000;
      errAcc_q <= 13'h0000;
      errLast_q <= 13'h0000;
    end else begin
      rxSh_q <= rxSh_d;
      locked_q <= locked_d;
      posRx_q <= posRx_d;
      rxWord_q <= rxWord_d;
      sampA_q <= sampA_d;
      rxUpd_q <= rxUpd_d;
      rxStat_q <= rxStat_d;
      hist_q <= hist_d;
      errAcc_q <= errAcc_d;
      errLast_q <= errLast_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_markerHigh;
    @(posedge clk_sys) disable iff (rst)
      (enable_q && posTx_q < 13'h0010) |=> txBit_q;
  endproperty
  a_markerHigh: assert property (p_markerHigh) else $error("marker high half wrong");

  property p_markerLow;
    @(posedge clk_sys) disable iff (rst)
      (enable_q && posTx_q >= 13'h0010 && posTx_q < CTRL_START) |=> !txBit_q;
  endproperty
  a_markerLow: assert property (p_markerLow) else $error("marker low half wrong");

  property p_cellEdge;
    @(posedge clk_sys) disable iff (rst)
      (inCtrlTx && offTx[2:0] == CELL_EDGE) |=> txBit_q != $past(txBit_q);
  endproperty
  a_cellEdge: assert property (p_cellEdge) else $error("no transition at cell edge");

  property p_cellMid;
    @(posedge clk_sys) disable iff (rst)
      (inCtrlTx && offTx[2:0] == CELL_MID) |=>
        (txBit_q != $past(txBit_q)) == $past(txWord[offTx[7:3]]);
  endproperty
  a_cellMid: assert property (p_cellMid) else $error("mid cell level wrong");

  property p_tailZero;
    @(posedge clk_sys) disable iff (rst)
      (enable_q && posTx_q > TRAIN_LAST) |=> !txBit_q;
  endproperty
  a_tailZero: assert property (p_tailZero) else $error("tail bits not zero");

  property p_backToBack;
    @(posedge clk_sys) disable iff (rst)
      (enable_q && posTx_q == FRAME_LEN - 13'h0001) ##1 enable_q |-> posTx_q == 13'h0000;
  endproperty
  a_backToBack: assert property (p_backToBack) else $error("gap between frames");

  property p_txResZero;
    @(posedge clk_sys) disable iff (rst)
      $changed(txUpd_q) |-> (txUpd_q & UPD_RES_MASK) == 16'h0000 && txUpd_q[5:4] != TAP_RES;
  endproperty
  a_txResZero: assert property (p_txResZero) else $error("reserved update bits sent");

  property p_presetHold;
    @(posedge clk_sys) disable iff (rst)
      (txUpd_q[PRESET_BIT] || txUpd_q[INIT_BIT]) |-> txUpd_q[5:0] == 6'h00;
  endproperty
  a_presetHold: assert property (p_presetHold) else $error("step with preset");

  property p_rxOnlyLocked;
    @(posedge clk_sys) disable iff (rst)
      ($changed(rxUpd_q) || $changed(rxStat_q)) |-> $past(locked_q) || locked_q;
  endproperty
  a_rxOnlyLocked: assert property (p_rxOnlyLocked) else $error("control used unaligned");

  property p_rxStatRes;
    @(posedge clk_sys) disable iff (rst)
      ((rxStat_q & STAT_RES_MASK) | (rxUpd_q & UPD_RES_MASK)) == 16'h0000;
  endproperty
  a_rxStatRes: assert property (p_rxStatRes) else $error("reserved bits kept");

  property p_bHold;
    @(posedge clk_sys) disable iff (rst)
      (bvalid && !bready) |=> bvalid && $stable(bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("write response dropped");

  c_lock: cover property (@(posedge clk_sys) disable iff (rst) $rose(locked_q));
  c_frameDone: cover property (@(posedge clk_sys) disable iff (rst)
    locked_q && posRx_q == FRAME_LEN - 13'h0001);
  c_remoteReady: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(rxStat_q[RXREADY_BIT]));
  c_write: cover property (@(posedge clk_sys) disable iff (rst) bvalid && bready);

endmodule : link_train_partner

// ==== verilog/link_train_pkg.sv ====
// Constants shared by the link training partner controller.
// Assumes one bit of the serial line per clk_sys cycle.
package link_train_pkg;

  // ----------------------------------------------------------------
  // Frame layout, in line bits
  // ----------------------------------------------------------------
  localparam logic [31:0] MARKER = 32'hFFFF0000;
  localparam logic [12:0] CTRL_START = 13'h0020;
  localparam logic [12:0] TRAIN_START = 13'h0120;
  localparam logic [12:0] FRAME_LEN = 13'h1120;
  localparam logic [12:0] TRAIN_LAST = 13'h111D;
  localparam logic [12:0] CHECK_START = 13'h012B;
  localparam logic [2:0] CELL_EDGE = 3'h0;
  localparam logic [2:0] CELL_MID = 3'h4;
  localparam logic [2:0] SAMPLE_A = 3'h2;
  localparam logic [2:0] SAMPLE_B = 3'h6;
  localparam logic [4:0] LAST_CELL = 5'h1F;
  localparam logic [10:0] PRBS_SEED = 11'h7FF;

  // ----------------------------------------------------------------
  // Control channel fields
  // ----------------------------------------------------------------
  localparam logic [15:0] UPD_RES_MASK = 16'hCFC0;
  localparam logic [15:0] STAT_RES_MASK = 16'h7FC0;
  localparam int PRESET_BIT = 13;
  localparam int INIT_BIT = 12;
  localparam int RXREADY_BIT = 15;
  localparam logic [1:0] TAP_HOLD = 2'h0;
  localparam logic [1:0] TAP_INC = 2'h1;
  localparam logic [1:0] TAP_DEC = 2'h2;
  localparam logic [1:0] TAP_RES = 2'h3;
  localparam logic [1:0] ST_MAX = 2'h3;
  localparam logic [1:0] ST_MIN = 2'h1;
  localparam logic [1:0] ST_UPD = 2'h2;
  localparam logic [1:0] ST_NUPD = 2'h0;

  // ----------------------------------------------------------------
  // Own registers, byte offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] OFF_CTRL = 32'h00000000;
  localparam logic [31:0] OFF_TX_UPD = 32'h00000004;
  localparam logic [31:0] OFF_TX_STAT = 32'h00000008;
  localparam logic [31:0] OFF_RX_UPD = 32'h0000000C;
  localparam logic [31:0] OFF_RX_STAT = 32'h00000010;
  localparam logic [31:0] OFF_LINK = 32'h00000014;
  localparam logic [31:0] OFF_ERRS = 32'h00000018;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // PRBS11 feedback, x^11 + x^9 + 1, newest bit at index 0
  function automatic logic prbsFb(input logic [10:0] s);
    prbsFb = s[10] ^ s[8];
  endfunction : prbsFb

  // Byte lane merge for a register write
  function automatic logic [31:0] applyStrobe(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    applyStrobe = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        applyStrobe[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction : applyStrobe

endpackage : link_train_pkg

// ==== verilog/prbs11_gen.sv ====
// PRBS11 pattern source for the training field.
// Assumes the caller holds load outside the training field.
module prbs11_gen (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic advance,
  // Pattern
  output logic bitOut
);
  import link_train_pkg::*;

  logic [10:0] state_q;
  logic [10:0] state_d;

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  // Next state: seed on load, shift on advance
  always_comb begin
    state_d = state_q;
    if (load) begin
      state_d = PRBS_SEED;
    end else if (advance) begin
      state_d = {state_q[9:0], prbsFb(state_q)};
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= PRBS_SEED;
    end else begin
      state_q <= state_d;
    end
  end

  assign bitOut = state_q[10]; // Oldest bit leaves first

endmodule : prbs11_gen

// ==== verif/train_device_model.sv ====
// Behavioural model of the training device on the far side of the line.
// Assumes one line bit per clk_sys and a bench that drives its controls.
module train_device_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Scenario controls
  input wire logic enable,
  input wire logic dirty,
  input wire logic [15:0] updWord,
  input wire logic [15:0] statWord,
  input wire logic [12:0] flipPos,
  // Serial line towards the controller
  output logic devBit
);
  timeunit 1ns;
  timeprecision 1ps;
  import link_train_pkg::*;

  logic [12:0] pos;
  logic [10:0] sr;
  logic lvl;
  logic [31:0] word;
  logic [12:0] off;

  // Control words, reserved bits cleared unless told to break that
  assign word = dirty ? {statWord, updWord} :
                {statWord & ~STAT_RES_MASK, updWord & ~UPD_RES_MASK};
  assign off = pos - CTRL_START;

  // ------------------------------------------------------------
  // Frame generator; toggles the idle line so no stale level shows
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst || !enable) begin
      devBit <= rst ? 1'b0 : ~devBit;
      pos <= 13'h0000;
      sr <= PRBS_SEED;
      lvl <= 1'b0;
    end else begin
      pos <= (pos == FRAME_LEN - 13'h0001) ? 13'h0000 : pos + 13'h0001;
      if (pos < CTRL_START) begin
        devBit <= MARKER[5'h1F - pos[4:0]];
        lvl <= 1'b0;
        sr <= PRBS_SEED;
      end else if (pos < TRAIN_START) begin
        if (off[2:0] == 3'h0 || (off[2:0] == 3'h4 && word[off[7:3]])) begin
          lvl <= ~lvl;
          devBit <= ~lvl;
        end else begin
          devBit <= lvl;
        end
      end else if (pos < FRAME_LEN - 13'h0002) begin
        devBit <= sr[10] ^ (pos == flipPos);
        sr <= {sr[9:0], sr[10] ^ sr[8]};
      end else begin
        devBit <= 1'b0;
      end
    end
  end
endmodule : train_device_model

// ==== verif/backplane_link_training_tb.sv ====
// Self-checking bench for the link training partner controller.
// Assumes the design package and the device model are compiled first.
module backplane_link_training_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import link_train_pkg::*;

  typedef struct packed {
    logic [31:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [31:0] e;
    logic [1:0] r;
  } row_t;

  // ------------------------------------------------------------
  // Register cases: address, data, strobe, read-back, response
  // ------------------------------------------------------------
  localparam row_t ROWS [11] = '{
    '{OFF_LINK, 32'hFFFFFFFF, 4'hF, 32'h00000000, RESP_OKAY},
    '{OFF_RX_UPD, 32'hFFFFFFFF, 4'hF, 32'h00000000, RESP_OKAY},
    '{OFF_TX_UPD, 32'h0000FFFF, 4'hF, 32'h00003000, RESP_OKAY},
    '{OFF_TX_UPD, 32'h0000003F, 4'hF, 32'h00000000, RESP_OKAY},
    '{OFF_TX_UPD, 32'h0000002A, 4'hF, 32'h0000002A, RESP_OKAY},
    '{OFF_TX_UPD, 32'h00001000, 4'h2, 32'h00001000, RESP_OKAY},
    '{OFF_TX_UPD, 32'h00000015, 4'hF, 32'h00000015, RESP_OKAY},
    '{OFF_TX_STAT, 32'hFFFFFFFF, 4'hF, 32'h0000803F, RESP_OKAY},
    '{OFF_TX_STAT, 32'h00008036, 4'hF, 32'h00008036, RESP_OKAY},
    '{32'h0000001C, 32'h12345678, 4'hF, 32'h00000000, RESP_SLVERR},
    '{OFF_ERRS, 32'hFFFFFFFF, 4'hF, 32'h00000000, RESP_OKAY}};
  // Single flips: before the check start, mid field, last bit
  localparam logic [12:0] FLIPS [3] = '{13'h0122, 13'h03E8, 13'h111D};
  localparam logic [31:0] FLIP_ERRS [3] = '{32'h00000002, 32'h00000003, 32'h00000001};

  logic clk_sys, rst, txBit, rxBit;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, wr, rr;
  logic modelEn, dirty;
  logic [15:0] updWord, statWord;
  logic [12:0] flipPos;
  int bad_count, comparisons, ones;

  link_train_partner DUT (
    .clk_sys(clk_sys), .rst(rst), .txBit(txBit), .rxBit(rxBit),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  train_device_model peer (
    .clk_sys(clk_sys), .rst(rst), .enable(modelEn), .dirty(dirty),
    .updWord(updWord), .statWord(statWord), .flipPos(flipPos), .devBit(rxBit));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic axiWrite(input logic [31:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge clk_sys); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge clk_sys); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge clk_sys); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead

  // Captures one sent frame after a marker and decodes it
  task automatic checkTxFrame;
    logic f [0:4383];
    logic [31:0] hist;
    logic [31:0] cw;
    int errs;
    int n;
    hist = 32'h00000000;
    errs = 0;
    n = 0;
    while (hist !== MARKER && n < 9000) begin
      @(posedge clk_sys);
      hist = {hist[30:0], txBit};
      n++;
    end
    for (int i = 0; i < 4384; i++) begin
      @(posedge clk_sys);
      f[(i + 32) % 4384] = txBit;
    end
    for (int p = 0; p < 32; p++) hist[31 - p] = f[p];
    for (int j = 0; j < 32; j++) begin
      cw[j] = f[32 + 8 * j + 2] ^ f[32 + 8 * j + 6];
      errs += int'(f[32 + 8 * j] === f[31 + 8 * j]);
    end
    for (int p = 299; p < 4382; p++) errs += int'(f[p] !== (f[p - 11] ^ f[p - 9]));
    errs += int'(f[4382] !== 1'b0) + int'(f[4383] !== 1'b0);
    check(hist, MARKER);
    check(cw, 32'h80360015);
    check(32'(errs), 32'h00000000);
  endtask : checkTxFrame

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, modelEn, dirty} = 7'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'h0;
    {updWord, statWord} = 32'h0;
    flipPos = 13'h0000;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      axiWrite(ROWS[i].a, ROWS[i].d, ROWS[i].s, wr);
      axiRead(ROWS[i].a, rd, rr);
      check(rd, ROWS[i].e);
      check({28'h0000000, wr, rr}, {28'h0000000, ROWS[i].r, ROWS[i].r});
    end
    // Own frames go out back to back once enabled
    axiWrite(OFF_CTRL, 32'h00000001, 4'hF, wr);
    checkTxFrame();
    // Received fields, reserved bits set on the line
    updWord <= 16'hFFE9;
    statWord <= 16'hFFF6;
    dirty <= 1'b1;
    modelEn <= 1'b1;
    repeat (3 * FRAME_LEN) @(posedge clk_sys);
    axiRead(OFF_RX_UPD, rd, rr);
    check(rd, 32'h00003029);
    axiRead(OFF_RX_STAT, rd, rr);
    check(rd, 32'h00008036);
    axiRead(OFF_LINK, rd, rr);
    check(rd, 32'h00000007);
    axiRead(OFF_ERRS, rd, rr);
    check(rd, 32'h00000000);
    // Counted errors for single flipped training bits
    foreach (FLIPS[k]) begin
      flipPos <= FLIPS[k];
      repeat (2 * FRAME_LEN) @(posedge clk_sys);
      axiRead(OFF_ERRS, rd, rr);
      check(rd, FLIP_ERRS[k]);
    end
    // Partner lost, then back: lock drops and returns
    modelEn <= 1'b0;
    repeat (2 * FRAME_LEN) @(posedge clk_sys);
    axiRead(OFF_LINK, rd, rr);
    check(rd, 32'h00000006);
    modelEn <= 1'b1;
    repeat (2 * FRAME_LEN) @(posedge clk_sys);
    axiRead(OFF_LINK, rd, rr);
    check(rd, 32'h00000007);
    // Sending stops: line held low
    axiWrite(OFF_CTRL, 32'h00000000, 4'hF, wr);
    repeat (2) @(posedge clk_sys);
    ones = 0;
    repeat (300) begin
      @(posedge clk_sys);
      ones += int'(txBit !== 1'b0);
    end
    check(32'(ones), 32'h00000000);
    axiRead(OFF_LINK, rd, rr);
    check(rd, 32'h00000003);
    // Mid-run reset: registers cleared, lock regained afterwards
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    axiRead(OFF_LINK, rd, rr);
    check(rd, 32'h00000000);
    axiRead(OFF_TX_UPD, rd, rr);
    check(rd, 32'h00000000);
    repeat (2 * FRAME_LEN) @(posedge clk_sys);
    axiRead(OFF_LINK, rd, rr);
    check(rd, 32'h00000003);
    tally_and_finish();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    tally_and_finish();
  end
endmodule : backplane_link_training_tb
